// ==== rtl/cra_defs.vh ====
// Register offsets, field positions, reset values and RAM map for the coefficient RAM window.
`ifndef CRA_DEFS_VH
`define CRA_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CRA_OFF_ADDR_HIGH   8'h3B
`define CRA_OFF_ADDR_LOW    8'h3C
`define CRA_OFF_B1_TOP      8'h3D
`define CRA_OFF_B1_MID      8'h3E
`define CRA_OFF_B1_LOW      8'h3F
`define CRA_OFF_B2_TOP      8'h40
`define CRA_OFF_B2_MID      8'h41
`define CRA_OFF_B2_LOW      8'h42
`define CRA_OFF_A1_TOP      8'h43
`define CRA_OFF_A1_MID      8'h44
`define CRA_OFF_A1_LOW      8'h45
`define CRA_OFF_A2_TOP      8'h46
`define CRA_OFF_A2_MID      8'h47
`define CRA_OFF_A2_LOW      8'h48
`define CRA_OFF_B0_TOP      8'h49
`define CRA_OFF_B0_MID      8'h4A
`define CRA_OFF_B0_LOW      8'h4B
`define CRA_OFF_WRITE_CTRL  8'h4C

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define CRA_ADDR_HIGH_W     2
`define CRA_BIT_COMMIT_SINGLE 0
`define CRA_BIT_COMMIT_SET    1
`define CRA_TERMS           5
`define CRA_DATA_REGS       15
`define CRA_BYTES_PER_TERM  3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRA_RST_BYTE        8'h00
`define CRA_RST_ADDR_HIGH   2'h0
`define CRA_RST_ADDR_LOW    8'h00
`define CRA_RST_DATA        8'h00
`define CRA_RST_READ        8'h00

// ----------------------------------------------------------------------
// Coefficient RAM map and power-up contents
// ----------------------------------------------------------------------
`define CRA_RAM_DEPTH       528
`define CRA_PRESCALE_BASE   400
`define CRA_POSTSCALE_BASE  408
`define CRA_MIX1_BASE       416
`define CRA_MIX2_BASE       464
`define CRA_MIX_DIAG_STEP   9
`define CRA_B0_TERM_POS     4
`define CRA_COEF_ZERO       24'h000000
`define CRA_COEF_HALF       24'h400000
`define CRA_COEF_UNITY      24'h7FFFFF

`endif

// ==== rtl/cra_coef_ram_access.v ====
// Coefficient RAM with its byte-wide register window, address loading and single/set commit.
`default_nettype none
`include "cra_defs.vh"

module cra_coef_ram_access #(
  parameter RAM_DEPTH = `CRA_RAM_DEPTH,
  parameter IDX_W     = 10,
  parameter COEF_W    = 24
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rst_n,
  // Byte register port from the control-bus engine
  input  wire [7:0]        regAddr,
  input  wire              regWrEn,
  input  wire [7:0]        regWrData,
  input  wire              regRdEn,
  output reg  [7:0]        regRdData,
  // Filter engine coefficient read port
  input  wire [IDX_W-1:0]  engRdIndex,
  output reg  [COEF_W-1:0] engRdData,
  // Commit status
  output reg               ramUpdated
);

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  reg  [`CRA_ADDR_HIGH_W-1:0] ramIndexHigh;
  reg  [7:0]                  ramIndexLow;
  reg                         commitSingle;
  reg                         commitSet;
  reg                         fetchPending;
  reg  [7:0]                  dataReg [0:`CRA_DATA_REGS-1];
  wire [IDX_W-1:0]            ramIndex;
  wire [7:0]                  dataSlot;
  wire                        wrHigh;
  wire                        wrLow;
  wire                        wrData;
  wire                        wrCtrl;
  wire                        rdData;
  wire [COEF_W-1:0]           ramWord   [0:RAM_DEPTH-1];
  wire [COEF_W-1:0]           termWord  [0:`CRA_TERMS-1];
  wire [COEF_W-1:0]           fetchWord [0:`CRA_TERMS-1];
  integer                     j;

  assign ramIndex = {ramIndexHigh, ramIndexLow};
  assign dataSlot = regAddr - `CRA_OFF_B1_TOP;
  assign wrHigh   = regWrEn && (regAddr == `CRA_OFF_ADDR_HIGH);
  assign wrLow    = regWrEn && (regAddr == `CRA_OFF_ADDR_LOW);
  assign rdData   = (regAddr >= `CRA_OFF_B1_TOP) && (regAddr <= `CRA_OFF_B0_LOW);
  assign wrData   = regWrEn && rdData;
  assign wrCtrl   = regWrEn && (regAddr == `CRA_OFF_WRITE_CTRL);

  // ----------------------------------------------------------------------
  // Per-term assembly and fetch from RAM
  // ----------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < `CRA_TERMS; k = k + 1) begin : gen_term
      localparam [IDX_W:0] TERM_OFS = k;
      wire [IDX_W:0] termIdx;
      // Top, middle and bottom bytes of each triple form one coefficient.
      assign termWord[k] = {dataReg[3*k], dataReg[3*k+1], dataReg[3*k+2]};
      assign termIdx     = {1'b0, ramIndex} + TERM_OFS;
      // Terms past the end of the RAM read as zero rather than wrapping.
      assign fetchWord[k] = (termIdx < RAM_DEPTH) ? ramWord[termIdx[IDX_W-1:0]] : `CRA_COEF_ZERO;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Coefficient RAM
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < RAM_DEPTH; i = i + 1) begin : gen_ram
      localparam MIX_POS = (i < `CRA_MIX2_BASE) ? (i - `CRA_MIX1_BASE) : (i - `CRA_MIX2_BASE);
      localparam [COEF_W-1:0] RST_VAL =
        (i < `CRA_PRESCALE_BASE) ?
          (((i % `CRA_TERMS) == `CRA_B0_TERM_POS) ? `CRA_COEF_HALF : `CRA_COEF_ZERO) :
        (i < `CRA_MIX1_BASE) ? `CRA_COEF_UNITY :
        (((MIX_POS % `CRA_MIX_DIAG_STEP) == 0) ? `CRA_COEF_UNITY : `CRA_COEF_ZERO);
      localparam [IDX_W:0] ENTRY_IDX = i;
      reg  [COEF_W-1:0] entry;
      wire [IDX_W:0]    rel;
      wire              hit;
      // Unsigned distance from the base; entries below the base wrap to large values.
      assign rel = ENTRY_IDX - {1'b0, ramIndex};
      assign hit = (commitSingle && (rel == 0)) ||
                   (commitSet && (rel < `CRA_TERMS));
      // All entries of a set share one edge, so no mix of old and new terms is seen.
      always @(posedge core_clk) begin
        if (!rst_n) begin
          entry <= RST_VAL;
        end else if (hit) begin
          entry <= termWord[rel[2:0]];
        end
      end
      assign ramWord[i] = entry;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Address, control and data registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ramIndexHigh <= `CRA_RST_ADDR_HIGH;
      ramIndexLow  <= `CRA_RST_ADDR_LOW;
      commitSingle <= 1'b0;
      commitSet    <= 1'b0;
      fetchPending <= 1'b0;
      ramUpdated   <= 1'b0;
      for (j = 0; j < `CRA_DATA_REGS; j = j + 1) begin
        dataReg[j] <= `CRA_RST_DATA;
      end
    end else begin
      if (wrHigh) begin
        ramIndexHigh <= regWrData[`CRA_ADDR_HIGH_W-1:0];
      end
      if (wrLow) begin
        ramIndexLow <= regWrData;
      end
      // A new address refreshes all triples from RAM on the following cycle.
      fetchPending <= wrHigh | wrLow;
      // Each commit bit lives for exactly the one cycle of the RAM write.
      commitSingle <= wrCtrl && regWrData[`CRA_BIT_COMMIT_SINGLE];
      commitSet    <= wrCtrl && regWrData[`CRA_BIT_COMMIT_SET];
      ramUpdated   <= commitSingle | commitSet;
      for (j = 0; j < `CRA_DATA_REGS; j = j + 1) begin
        // A host write in the fetch cycle wins over the fetched byte.
        if (wrData && (dataSlot[3:0] == j)) begin
          dataReg[j] <= regWrData;
        end else if (fetchPending) begin
          dataReg[j] <= fetchWord[j / 3][8 * (2 - (j % 3)) +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= `CRA_RST_READ;
      engRdData <= `CRA_COEF_ZERO;
    end else begin
      engRdData <= (engRdIndex < RAM_DEPTH) ? ramWord[engRdIndex] : `CRA_COEF_ZERO;
      if (regRdEn) begin
        if (regAddr == `CRA_OFF_ADDR_HIGH) begin
          regRdData <= {6'h00, ramIndexHigh};
        end else if (regAddr == `CRA_OFF_ADDR_LOW) begin
          regRdData <= ramIndexLow;
        end else if (rdData) begin
          regRdData <= dataReg[dataSlot[3:0]];
        end else if (regAddr == `CRA_OFF_WRITE_CTRL) begin
          regRdData <= {6'h00, commitSet, commitSingle};
        end else begin
          regRdData <= `CRA_RST_READ;
        end
      end
    end
  end

endmodule // cra_coef_ram_access
`default_nettype wire

// ==== sim/cra_monitor.sv ====
// Concurrent checks on the ports of the coefficient RAM register window.
`default_nettype none
module cra_monitor #(
  parameter RAM_DEPTH = 528,
  parameter IDX_W     = 10,
  parameter COEF_W    = 24
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [7:0]        regAddr,
  input wire logic              regWrEn,
  input wire logic [7:0]        regWrData,
  input wire logic              regRdEn,
  input wire logic [7:0]        regRdData,
  // Engine port and status
  input wire logic [IDX_W-1:0]  engRdIndex,
  input wire logic [COEF_W-1:0] engRdData,
  input wire logic              ramUpdated
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_commitWr; regWrEn && regAddr == 8'h4C && regWrData[1:0] != 2'h0; endsequence
  sequence s_ctrlRd; regRdEn && regAddr == 8'h4C; endsequence
  property p_addrPad; regRdEn && regAddr == 8'h3B |=> regRdData[7:2] == 6'h00; endproperty
  a_addrPad: assert property (p_addrPad) else $error("address pad bits set");
  property p_ctrlPad; s_ctrlRd |=> regRdData[7:2] == 6'h00; endproperty
  a_ctrlPad: assert property (p_ctrlPad) else $error("control pad bits set");
  property p_ctrlClear; s_ctrlRd ##0 !$past(regWrEn && regAddr == 8'h4C) |=> regRdData == 8'h00; endproperty
  a_ctrlClear: assert property (p_ctrlClear) else $error("commit bit kept");
  property p_rdHold; !regRdEn |=> $stable(regRdData); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read byte moved");
  property p_unmapped; regRdEn && (regAddr < 8'h3B || regAddr > 8'h4C) |=> regRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_commitPulse; s_commitWr |-> ##2 ramUpdated; endproperty
  a_commitPulse: assert property (p_commitPulse) else $error("no update pulse");
  property p_pulseCause; ramUpdated |-> $past(regWrEn && regAddr == 8'h4C && regWrData[1:0] != 2'h0, 2); endproperty
  a_pulseCause: assert property (p_pulseCause) else $error("stray update pulse");
  property p_engBeyond; engRdIndex >= RAM_DEPTH |=> engRdData == '0; endproperty
  a_engBeyond: assert property (p_engBeyond) else $error("word past map not zero");
endmodule // cra_monitor
bind cra_coef_ram_access cra_monitor #(.RAM_DEPTH(RAM_DEPTH), .IDX_W(IDX_W), .COEF_W(COEF_W)) i_cra_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .engRdIndex(engRdIndex), .engRdData(engRdData), .ramUpdated(ramUpdated));
`default_nettype wire

// ==== sim/cra_host_model.sv ====
// Control-port host model: byte writes, byte reads and address-plus-data loads.
`default_nettype none
module cra_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  logic [7:0] regAddr,
  output var  logic       regWrEn,
  output var  logic [7:0] regWrData,
  output var  logic       regRdEn,
  input  wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {regAddr, regWrEn, regWrData, regRdEn} = 18'h0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
    @(posedge core_clk);
    // A released data line must not keep looking valid.
    {regWrData, regWrEn} <= {~d, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    {regAddr, regRdEn} <= {a, 1'b1};
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 q = regRdData;
  endtask
  task load(input logic [9:0] idx, input int n, input logic [119:0] v);
    wr(8'h3B, {6'h00, idx[9:8]});
    wr(8'h3C, idx[7:0]);
    for (int i = 0; i < n; i++) wr(8'h3D + i[7:0], v[119-8*i -: 8]);
  endtask
endmodule // cra_host_model
`default_nettype wire

// ==== sim/cra_coef_ram_access_bench.sv ====
// Self-checking bench for the coefficient RAM register window.
`default_nettype none
module cra_coef_ram_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  engRdIndex = 10'h000;
  logic [7:0]  regAddr, regWrData, regRdData, q;
  logic        regWrEn, regRdEn, ramUpdated;
  logic [23:0] engRdData;
  logic [119:0] setVal = 120'hA1A2A3_B1B2B3_C1C2C3_D1D2D3_E1E2E3;
  int          failures = 0;
  int          samplesChecked = 0;
  always #2 core_clk = ~core_clk;
  cra_coef_ram_access i_cra_coef_ram_access (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .engRdIndex(engRdIndex), .engRdData(engRdData), .ramUpdated(ramUpdated));
  cra_host_model i_cra_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  task final_report;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    samplesChecked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdChk(input logic [7:0] a, input logic [7:0] e);
    i_cra_host_model.rd(a, q);
    chk($sformatf("register %h", a), {16'h0, q}, {16'h0, e});
  endtask
  task rdSet(input logic [119:0] e);
    for (int i = 0; i < 15; i++) rdChk(8'h3D + i[7:0], e[119-8*i -: 8]);
  endtask
  task eng(input logic [9:0] idx, input logic [23:0] e);
    @(posedge core_clk);
    engRdIndex <= idx;
    @(posedge core_clk);
    #1 chk("engine word", engRdData, e);
  endtask
  task waitPulse;
    int i;
    for (i = 0; i < 8 && ramUpdated !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("update pulse", {23'h0, ramUpdated}, 24'h1);
    if (i == 8) final_report;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 8'h3B; a <= 8'h4C; a++) rdChk(a[7:0], 8'h00);
    $display("test reset values done");
    i_cra_host_model.load(10'd0, 0, 120'h0);
    rdSet({96'h0, 24'h400000});
    i_cra_host_model.wr(8'h3B, 8'hFD);
    i_cra_host_model.wr(8'h3C, 8'h90);
    rdChk(8'h3B, 8'h01);
    rdSet({5{24'h7FFFFF}});
    eng(10'h3FF, 24'h0);
    $display("test default contents done");
    i_cra_host_model.load(10'd7, 3, {24'h123456, 96'h0});
    i_cra_host_model.wr(8'h4C, 8'h01);
    waitPulse;
    rdChk(8'h4C, 8'h00);
    eng(10'd7, 24'h123456);
    i_cra_host_model.load(10'd7, 0, 120'h0);
    rdSet({24'h123456, 24'h0, 24'h400000, 48'h0});
    $display("test single commit done");
    i_cra_host_model.load(10'd395, 15, setVal);
    i_cra_host_model.wr(8'h4C, 8'h02);
    waitPulse;
    for (int k = 0; k < 5; k++) eng(10'd395 + k[9:0], setVal[119-24*k -: 24]);
    eng(10'd400, 24'h7FFFFF);
    $display("test set commit done");
    i_cra_host_model.wr(8'h50, 8'hAA);
    rdChk(8'h50, 8'h00);
    rdChk(8'h3A, 8'h00);
    $display("test unmapped offsets done");
    final_report;
  end
endmodule // cra_coef_ram_access_bench
`default_nettype wire
